/* File: rtl/ivm_sync2.v */
// two-flop synchroniser for one pin input
`timescale 1ns/1ps
`default_nettype none
module ivm_sync2
(
	// clock and reset
	input  wire clk,
	input  wire rst_n,
	// level in and out
	input  wire din,
	output wire dout
);
	reg meta_r;
	reg sync_r;

	always @(posedge clk)
	begin
		if (!rst_n)
		begin
			meta_r <= 1'b0;
			sync_r <= 1'b0;
		end
		else
		begin
			meta_r <= din;
			sync_r <= meta_r;
		end
	end

	assign dout = sync_r;
endmodule // ivm_sync2
`default_nettype wire

/* File: rtl/ivm_vec_calc.v */
// request number to vector number and table addresses
`timescale 1ns/1ps
`default_nettype none
`include "ivm_consts.vh"
module ivm_vec_calc
(
	// request number in
	input  wire [`IVM_IRQ_W-1:0]  irq_num,
	// mapping out
	output wire [`IVM_VEC_W-1:0]  vec_num,
	output wire [`IVM_ADDR_W-1:0] pri_addr,
	output wire [`IVM_ADDR_W-1:0] alt_addr
);
	wire [`IVM_ADDR_W-1:0] irq_wide;

	assign irq_wide = {{(`IVM_ADDR_W-`IVM_IRQ_W){1'b0}}, irq_num};
	assign vec_num  = irq_num + `IVM_VEC_BASE;
	assign pri_addr = `IVM_PRI_BASE + {irq_wide[`IVM_ADDR_W-2:0], 1'b0};
	assign alt_addr = pri_addr + `IVM_ALT_OFFSET;
endmodule // ivm_vec_calc
`default_nettype wire

/* File: rtl/ivm_vector_map.v */
// interrupt request routing and vector table address mapping
// Operation
// - vector number is request number plus eight, 0 to 8, 45 to 53
// - primary table entry at 0x000014 plus twice the request number
// - alternate table entry lies exactly 0x100 above the primary entry
// - external pin interrupts 0, 1, 2 go to requests 0, 20, 29
// - capture 1,2 to 1,5; 7,8 to 22,23; 3..6 to 37..40
// - compare 1,2 to 2,6; 3,4 to 25,26; 5..8 to 41..44
// - transfer channels 0..3 raise requests 4, 14, 24, 36
// - serial port 1 error 9, done 10; port 2 error 32, done 33
// - uart 1 receive 11, transmit 12; uart 2 receive 30, transmit 31
// - converter 1 done is request 13, converter 2 done is 21
// - two-wire 1 slave events request 16, master events request 17
// - can receive-data-ready is request 34, can event is 35
// - pin change notification is request 19
`timescale 1ns/1ps
`default_nettype none
`include "ivm_consts.vh"
module ivm_vector_map
(
	// clock and reset
	input  wire                    clk,
	input  wire                    rst_n,
	// external pin interrupts, asynchronous
	input  wire                    ext_pin_irq_0,
	input  wire                    ext_pin_irq_1,
	input  wire                    ext_pin_irq_2,
	// capture and compare units, index 0 is unit 1
	input  wire [7:0]              capture_irq,
	input  wire [7:0]              compare_irq,
	// timers, index 0 is timer 1
	input  wire [4:0]              timer_irq,
	// transfer channels 0..3
	input  wire [3:0]              transfer_irq,
	// serial, uart, converter, two-wire, can, pin change
	input  wire                    serial_port_1_error_irq,
	input  wire                    serial_port_1_done_irq,
	input  wire                    serial_port_2_error_irq,
	input  wire                    serial_port_2_done_irq,
	input  wire                    uart_1_receive_irq,
	input  wire                    uart_1_transmit_irq,
	input  wire                    uart_2_receive_irq,
	input  wire                    uart_2_transmit_irq,
	input  wire                    converter_1_done_irq,
	input  wire                    converter_2_done_irq,
	input  wire                    two_wire_1_slave_irq,
	input  wire                    two_wire_1_master_irq,
	input  wire                    can_1_receive_irq,
	input  wire                    can_1_event_irq,
	input  wire                    pin_change_irq,
	// lookup port for the core's vector fetch
	input  wire [`IVM_IRQ_W-1:0]   lookup_irq,
	output reg  [`IVM_VEC_W-1:0]   lookup_vec_r,
	output reg  [`IVM_ADDR_W-1:0]  lookup_pri_r,
	output reg  [`IVM_ADDR_W-1:0]  lookup_alt_r,
	output reg                     lookup_valid_r,
	// request vector and pending mapping to the core
	output reg  [`IVM_NUM_IRQ-1:0] irq_req_r,
	output reg                     pend_any_r,
	output reg  [`IVM_IRQ_W-1:0]   pend_irq_r,
	output reg  [`IVM_VEC_W-1:0]   pend_vec_r,
	output reg  [`IVM_ADDR_W-1:0]  pend_pri_r,
	output reg  [`IVM_ADDR_W-1:0]  pend_alt_r
);
	wire                    ext0_s;
	wire                    ext1_s;
	wire                    ext2_s;
	reg  [`IVM_NUM_IRQ-1:0] req_nxt;
	reg  [`IVM_IRQ_W-1:0]   low_nxt;
	reg                     any_nxt;
	wire [`IVM_VEC_W-1:0]   lk_vec;
	wire [`IVM_ADDR_W-1:0]  lk_pri;
	wire [`IVM_ADDR_W-1:0]  lk_alt;
	wire [`IVM_VEC_W-1:0]   pd_vec;
	wire [`IVM_ADDR_W-1:0]  pd_pri;
	wire [`IVM_ADDR_W-1:0]  pd_alt;

	// pins come from outside the clock domain
	ivm_sync2 u_sync0
	(
		.clk   (clk),
		.rst_n (rst_n),
		.din   (ext_pin_irq_0),
		.dout  (ext0_s)
	);

	ivm_sync2 u_sync1
	(
		.clk   (clk),
		.rst_n (rst_n),
		.din   (ext_pin_irq_1),
		.dout  (ext1_s)
	);

	ivm_sync2 u_sync2
	(
		.clk   (clk),
		.rst_n (rst_n),
		.din   (ext_pin_irq_2),
		.dout  (ext2_s)
	);

	// source routing onto request numbers
	always @*
	begin
		req_nxt = {`IVM_NUM_IRQ{1'b0}};
		req_nxt[`IVM_IRQ_EXT0]      = ext0_s;
		req_nxt[`IVM_IRQ_EXT1]      = ext1_s;
		req_nxt[`IVM_IRQ_EXT2]      = ext2_s;
		req_nxt[`IVM_IRQ_CAP1]      = capture_irq[0];
		req_nxt[`IVM_IRQ_CAP2]      = capture_irq[1];
		req_nxt[`IVM_IRQ_CAP7]      = capture_irq[6];
		req_nxt[`IVM_IRQ_CAP8]      = capture_irq[7];
		req_nxt[`IVM_IRQ_CAP3]      = capture_irq[2];
		req_nxt[`IVM_IRQ_CAP4]      = capture_irq[3];
		req_nxt[`IVM_IRQ_CAP5]      = capture_irq[4];
		req_nxt[`IVM_IRQ_CAP6]      = capture_irq[5];
		req_nxt[`IVM_IRQ_CMP1]      = compare_irq[0];
		req_nxt[`IVM_IRQ_CMP2]      = compare_irq[1];
		req_nxt[`IVM_IRQ_CMP3]      = compare_irq[2];
		req_nxt[`IVM_IRQ_CMP4]      = compare_irq[3];
		req_nxt[`IVM_IRQ_CMP5]      = compare_irq[4];
		req_nxt[`IVM_IRQ_CMP6]      = compare_irq[5];
		req_nxt[`IVM_IRQ_CMP7]      = compare_irq[6];
		req_nxt[`IVM_IRQ_CMP8]      = compare_irq[7];
		req_nxt[`IVM_IRQ_XFER0]     = transfer_irq[0];
		req_nxt[`IVM_IRQ_XFER1]     = transfer_irq[1];
		req_nxt[`IVM_IRQ_XFER2]     = transfer_irq[2];
		req_nxt[`IVM_IRQ_XFER3]     = transfer_irq[3];
		req_nxt[`IVM_IRQ_SER1_ERR]  = serial_port_1_error_irq;
		req_nxt[`IVM_IRQ_SER1_DONE] = serial_port_1_done_irq;
		req_nxt[`IVM_IRQ_SER2_ERR]  = serial_port_2_error_irq;
		req_nxt[`IVM_IRQ_SER2_DONE] = serial_port_2_done_irq;
		req_nxt[`IVM_IRQ_UART1_RX]  = uart_1_receive_irq;
		req_nxt[`IVM_IRQ_UART1_TX]  = uart_1_transmit_irq;
		req_nxt[`IVM_IRQ_UART2_RX]  = uart_2_receive_irq;
		req_nxt[`IVM_IRQ_UART2_TX]  = uart_2_transmit_irq;
		req_nxt[`IVM_IRQ_CONV1]     = converter_1_done_irq;
		req_nxt[`IVM_IRQ_CONV2]     = converter_2_done_irq;
		req_nxt[`IVM_IRQ_TW1_SLV]   = two_wire_1_slave_irq;
		req_nxt[`IVM_IRQ_TW1_MST]   = two_wire_1_master_irq;
		req_nxt[`IVM_IRQ_CAN_RX]    = can_1_receive_irq;
		req_nxt[`IVM_IRQ_CAN_EVT]   = can_1_event_irq;
		req_nxt[`IVM_IRQ_PINCHG]    = pin_change_irq;
		req_nxt[`IVM_IRQ_TMR1]      = timer_irq[0];
		req_nxt[`IVM_IRQ_TMR2]      = timer_irq[1];
		req_nxt[`IVM_IRQ_TMR3]      = timer_irq[2];
		req_nxt[`IVM_IRQ_TMR4]      = timer_irq[3];
		req_nxt[`IVM_IRQ_TMR5]      = timer_irq[4];
		// held low last so no stray write can reach them
		req_nxt[`IVM_IRQ_RSVD15]    = 1'b0;
		req_nxt[`IVM_IRQ_RSVD18]    = 1'b0;
		req_nxt[`IVM_IRQ_RSVD45]    = 1'b0;
	end

	// lowest pending number; natural order stands in for priority here
	// an explicit chain, so no loop variable is shared between processes
	always @*
	begin
		any_nxt = |irq_req_r;
		if (irq_req_r[0])
			low_nxt = 6'h00;
		else if (irq_req_r[1])
			low_nxt = 6'h01;
		else if (irq_req_r[2])
			low_nxt = 6'h02;
		else if (irq_req_r[3])
			low_nxt = 6'h03;
		else if (irq_req_r[4])
			low_nxt = 6'h04;
		else if (irq_req_r[5])
			low_nxt = 6'h05;
		else if (irq_req_r[6])
			low_nxt = 6'h06;
		else if (irq_req_r[7])
			low_nxt = 6'h07;
		else if (irq_req_r[8])
			low_nxt = 6'h08;
		else if (irq_req_r[9])
			low_nxt = 6'h09;
		else if (irq_req_r[10])
			low_nxt = 6'h0a;
		else if (irq_req_r[11])
			low_nxt = 6'h0b;
		else if (irq_req_r[12])
			low_nxt = 6'h0c;
		else if (irq_req_r[13])
			low_nxt = 6'h0d;
		else if (irq_req_r[14])
			low_nxt = 6'h0e;
		else if (irq_req_r[15])
			low_nxt = 6'h0f;
		else if (irq_req_r[16])
			low_nxt = 6'h10;
		else if (irq_req_r[17])
			low_nxt = 6'h11;
		else if (irq_req_r[18])
			low_nxt = 6'h12;
		else if (irq_req_r[19])
			low_nxt = 6'h13;
		else if (irq_req_r[20])
			low_nxt = 6'h14;
		else if (irq_req_r[21])
			low_nxt = 6'h15;
		else if (irq_req_r[22])
			low_nxt = 6'h16;
		else if (irq_req_r[23])
			low_nxt = 6'h17;
		else if (irq_req_r[24])
			low_nxt = 6'h18;
		else if (irq_req_r[25])
			low_nxt = 6'h19;
		else if (irq_req_r[26])
			low_nxt = 6'h1a;
		else if (irq_req_r[27])
			low_nxt = 6'h1b;
		else if (irq_req_r[28])
			low_nxt = 6'h1c;
		else if (irq_req_r[29])
			low_nxt = 6'h1d;
		else if (irq_req_r[30])
			low_nxt = 6'h1e;
		else if (irq_req_r[31])
			low_nxt = 6'h1f;
		else if (irq_req_r[32])
			low_nxt = 6'h20;
		else if (irq_req_r[33])
			low_nxt = 6'h21;
		else if (irq_req_r[34])
			low_nxt = 6'h22;
		else if (irq_req_r[35])
			low_nxt = 6'h23;
		else if (irq_req_r[36])
			low_nxt = 6'h24;
		else if (irq_req_r[37])
			low_nxt = 6'h25;
		else if (irq_req_r[38])
			low_nxt = 6'h26;
		else if (irq_req_r[39])
			low_nxt = 6'h27;
		else if (irq_req_r[40])
			low_nxt = 6'h28;
		else if (irq_req_r[41])
			low_nxt = 6'h29;
		else if (irq_req_r[42])
			low_nxt = 6'h2a;
		else if (irq_req_r[43])
			low_nxt = 6'h2b;
		else if (irq_req_r[44])
			low_nxt = 6'h2c;
		else if (irq_req_r[45])
			low_nxt = 6'h2d;
		else
			low_nxt = `IVM_NO_IRQ;
	end

	ivm_vec_calc u_lookup
	(
		.irq_num  (lookup_irq),
		.vec_num  (lk_vec),
		.pri_addr (lk_pri),
		.alt_addr (lk_alt)
	);

	ivm_vec_calc u_pend
	(
		.irq_num  (low_nxt),
		.vec_num  (pd_vec),
		.pri_addr (pd_pri),
		.alt_addr (pd_alt)
	);

	// lookup answers every cycle, independent of what is pending
	always @(posedge clk)
	begin
		if (!rst_n)
		begin
			lookup_vec_r   <= {`IVM_VEC_W{1'b0}};
			lookup_pri_r   <= {`IVM_ADDR_W{1'b0}};
			lookup_alt_r   <= {`IVM_ADDR_W{1'b0}};
			lookup_valid_r <= 1'b0;
		end
		else
		begin
			lookup_vec_r   <= lk_vec;
			lookup_pri_r   <= lk_pri;
			lookup_alt_r   <= lk_alt;
			// numbers past the table get no entry
			lookup_valid_r <= (lookup_irq < `IVM_NUM_IRQ);
		end
	end

	// pending follows the registered requests, one cycle behind
	always @(posedge clk)
	begin
		if (!rst_n)
		begin
			irq_req_r      <= {`IVM_NUM_IRQ{1'b0}};
			pend_any_r     <= 1'b0;
			pend_irq_r     <= `IVM_NO_IRQ;
			pend_vec_r     <= {`IVM_VEC_W{1'b0}};
			pend_pri_r     <= {`IVM_ADDR_W{1'b0}};
			pend_alt_r     <= {`IVM_ADDR_W{1'b0}};
		end
		else
		begin
			irq_req_r      <= req_nxt;
			pend_any_r     <= any_nxt;
			pend_irq_r     <= low_nxt;
			pend_vec_r     <= any_nxt ? pd_vec : {`IVM_VEC_W{1'b0}};
			pend_pri_r     <= any_nxt ? pd_pri : {`IVM_ADDR_W{1'b0}};
			pend_alt_r     <= any_nxt ? pd_alt : {`IVM_ADDR_W{1'b0}};
		end
	end
endmodule // ivm_vector_map
`default_nettype wire

/* File: shared/ivm_consts.vh */
// constants for the interrupt vector map
`ifndef IVM_CONSTS_VH
`define IVM_CONSTS_VH

`define IVM_NUM_IRQ        46
`define IVM_IRQ_W          6
`define IVM_VEC_W          6
`define IVM_ADDR_W         24
`define IVM_VEC_BASE       6'h08
`define IVM_PRI_BASE       24'h000014
`define IVM_ALT_OFFSET     24'h000100
`define IVM_NO_IRQ         6'h3f

// request numbers
`define IVM_IRQ_EXT0       0
`define IVM_IRQ_CAP1       1
`define IVM_IRQ_CMP1       2
`define IVM_IRQ_TMR1       3
`define IVM_IRQ_XFER0      4
`define IVM_IRQ_CAP2       5
`define IVM_IRQ_CMP2       6
`define IVM_IRQ_TMR2       7
`define IVM_IRQ_TMR3       8
`define IVM_IRQ_SER1_ERR   9
`define IVM_IRQ_SER1_DONE  10
`define IVM_IRQ_UART1_RX   11
`define IVM_IRQ_UART1_TX   12
`define IVM_IRQ_CONV1      13
`define IVM_IRQ_XFER1      14
`define IVM_IRQ_RSVD15     15
`define IVM_IRQ_TW1_SLV    16
`define IVM_IRQ_TW1_MST    17
`define IVM_IRQ_RSVD18     18
`define IVM_IRQ_PINCHG     19
`define IVM_IRQ_EXT1       20
`define IVM_IRQ_CONV2      21
`define IVM_IRQ_CAP7       22
`define IVM_IRQ_CAP8       23
`define IVM_IRQ_XFER2      24
`define IVM_IRQ_CMP3       25
`define IVM_IRQ_CMP4       26
`define IVM_IRQ_TMR4       27
`define IVM_IRQ_TMR5       28
`define IVM_IRQ_EXT2       29
`define IVM_IRQ_UART2_RX   30
`define IVM_IRQ_UART2_TX   31
`define IVM_IRQ_SER2_ERR   32
`define IVM_IRQ_SER2_DONE  33
`define IVM_IRQ_CAN_RX     34
`define IVM_IRQ_CAN_EVT    35
`define IVM_IRQ_XFER3      36
`define IVM_IRQ_CAP3       37
`define IVM_IRQ_CAP4       38
`define IVM_IRQ_CAP5       39
`define IVM_IRQ_CAP6       40
`define IVM_IRQ_CMP5       41
`define IVM_IRQ_CMP6       42
`define IVM_IRQ_CMP7       43
`define IVM_IRQ_CMP8       44
`define IVM_IRQ_RSVD45     45

`endif

/* File: testbench/interrupt_vector_map_tb.sv */
// self-checking bench for the interrupt vector map
`timescale 1ns/1ps
`default_nettype none
module interrupt_vector_map_tb;
	logic clk = 1'b0, rst_n = 1'b0, live = 1'b0, fetch_pend = 1'b0;
	logic ext_pin_irq_0 = 1'b0, ext_pin_irq_1 = 1'b0, ext_pin_irq_2 = 1'b0;
	logic [7:0] capture_irq = 8'h00, compare_irq = 8'h00;
	logic [4:0] timer_irq = 5'h00;
	logic [3:0] transfer_irq = 4'h0;
	logic [14:0] misc = 15'h0000;
	logic [5:0] probe_irq = 6'h00, lookup_irq, lookup_vec_r, pend_irq_r, pend_vec_r;
	logic lookup_valid_r, pend_any_r;
	logic [23:0] lookup_pri_r, lookup_alt_r, pend_pri_r, pend_alt_r;
	logic [45:0] irq_req_r;
	logic [45:0] ex_q[$];
	logic [2:0] pin_q[$] = '{3'h0, 3'h0};
	logic [5:0] lk_q[$];
	int miscompares = 0, tests_run = 0, cycles = 0;
	int pi[3] = '{0, 20, 29};
	int ci[8] = '{1, 5, 37, 38, 39, 40, 22, 23};
	int oi[8] = '{2, 6, 25, 26, 41, 42, 43, 44};
	int di[4] = '{4, 14, 24, 36};
	int ti[5] = '{3, 7, 8, 27, 28};
	int mi[15] = '{9, 10, 32, 33, 11, 12, 30, 31, 13, 21, 16, 17, 34, 35, 19};
	always #20 clk = ~clk;
	ivm_vector_map uut
	(
		.*,
		.serial_port_1_error_irq(misc[0]), .serial_port_1_done_irq(misc[1]),
		.serial_port_2_error_irq(misc[2]), .serial_port_2_done_irq(misc[3]),
		.uart_1_receive_irq(misc[4]), .uart_1_transmit_irq(misc[5]),
		.uart_2_receive_irq(misc[6]), .uart_2_transmit_irq(misc[7]),
		.converter_1_done_irq(misc[8]), .converter_2_done_irq(misc[9]),
		.two_wire_1_slave_irq(misc[10]), .two_wire_1_master_irq(misc[11]),
		.can_1_receive_irq(misc[12]), .can_1_event_irq(misc[13]),
		.pin_change_irq(misc[14])
	);
	ivm_core_model core (.*);
	task automatic check(input string what, input logic [47:0] seen, exp);
		tests_run++;
		if (seen !== exp)
		begin
			miscompares++;
			$display("ERROR %s expected %h seen %h", what, exp, seen);
		end
	endtask
	task automatic close_out();
		if (miscompares == 0 && tests_run > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask
	function automatic logic [45:0] same_clock();
		logic [45:0] r;
		r = '0;
		for (int k = 0; k < 15; k++)
		begin
			r[mi[k]] = misc[k];
			if (k < 8)
			begin
				r[ci[k]] = capture_irq[k];
				r[oi[k]] = compare_irq[k];
			end
			if (k < 5)
				r[ti[k]] = timer_irq[k];
			if (k < 4)
				r[di[k]] = transfer_irq[k];
		end
		return r;
	endfunction
	// history taken from pre-edge values, so the bench's own drives never race
	always @(posedge clk)
	begin
		logic [45:0] e;
		live = rst_n;
		cycles++;
		pin_q.push_front({ext_pin_irq_2, ext_pin_irq_1, ext_pin_irq_0});
		e = same_clock();
		for (int k = 0; k < 3; k++)
			e[pi[k]] = pin_q[2][k];
		ex_q.push_front(e);
		lk_q.push_front(lookup_irq);
		if (cycles > 4000)
		begin
			miscompares++;
			close_out();
		end
	end
	always @(negedge clk)
		if (live)
		begin
			int n;
			check("requests", irq_req_r, ex_q[0]);
			n = -1;
			for (int k = 45; k >= 0; k--)
				if (ex_q[1][k])
					n = k;
			check("pend flag", pend_any_r, n >= 0);
			check("pend number", pend_irq_r, n < 0 ? 63 : n);
			check("pend vector", pend_vec_r, n < 0 ? 0 : n + 8);
			check("pend primary", pend_pri_r, n < 0 ? 0 : 20 + 2 * n);
			check("pend alternate", pend_alt_r, n < 0 ? 0 : 276 + 2 * n);
			n = lk_q[0];
			check("lookup valid", lookup_valid_r, n < 46);
			if (n < 46)
			begin
				check("lookup vector", lookup_vec_r, n + 8);
				check("lookup primary", lookup_pri_r, 20 + 2 * n);
				check("lookup alternate", lookup_alt_r, 276 + 2 * n);
			end
		end
	task automatic drive();
		@(posedge clk);
		{ext_pin_irq_2, ext_pin_irq_1, ext_pin_irq_0, capture_irq, compare_irq}
			<= 19'($urandom & $urandom);
		{timer_irq, transfer_irq, misc} <= 24'($urandom & $urandom);
		probe_irq <= 6'($urandom);
		fetch_pend <= 1'($urandom);
	endtask
	initial
	begin
		void'($urandom(32'h773af6d2));
		repeat (3) @(posedge clk);
		rst_n <= 1'b1;
		repeat (1500) drive();
		@(posedge clk);
		rst_n <= 1'b0;
		{ext_pin_irq_2, ext_pin_irq_1, ext_pin_irq_0, capture_irq, compare_irq}
			<= 19'h00000;
		{timer_irq, transfer_irq, misc} <= 24'h000000;
		repeat (3) @(posedge clk);
		rst_n <= 1'b1;
		repeat (1500) drive();
		repeat (2) @(negedge clk);
		close_out();
	end
endmodule // interrupt_vector_map_tb
bind ivm_vector_map ivm_vector_map_chk chk (.*);
`default_nettype wire

/* File: testbench/ivm_core_model.sv */
// processor core vector fetch model driving the lookup port
`timescale 1ns/1ps
`default_nettype none
module ivm_core_model
(
	// clock and reset
	input  wire logic       clk,
	input  wire logic       rst_n,
	// pending request and the bench's fetch choice
	input  wire logic       pend_any_r,
	input  wire logic [5:0] pend_irq_r,
	input  wire logic       fetch_pend,
	input  wire logic [5:0] probe_irq,
	// lookup request to the map
	output var  logic [5:0] lookup_irq
);
	// a fetch reuses the pending number a cycle late, as a real core would
	always @(posedge clk)
	begin
		if (!rst_n)
			lookup_irq <= 6'h00;
		else if (fetch_pend && pend_any_r)
			lookup_irq <= pend_irq_r;
		else
			lookup_irq <= probe_irq;
	end
endmodule // ivm_core_model
`default_nettype wire

/* File: testbench/ivm_vector_map_chk.sv */
// concurrent checks on the vector map ports
`timescale 1ns/1ps
`default_nettype none
module ivm_vector_map_chk
(
	// clock and reset
	input  wire logic        clk,
	input  wire logic        rst_n,
	// pin sources
	input  wire logic        ext_pin_irq_0,
	input  wire logic        ext_pin_irq_1,
	input  wire logic        ext_pin_irq_2,
	// grouped sources
	input  wire logic [7:0]  capture_irq,
	input  wire logic [7:0]  compare_irq,
	input  wire logic [4:0]  timer_irq,
	input  wire logic [3:0]  transfer_irq,
	// single sources
	input  wire logic        serial_port_1_error_irq,
	input  wire logic        serial_port_1_done_irq,
	input  wire logic        serial_port_2_error_irq,
	input  wire logic        serial_port_2_done_irq,
	input  wire logic        uart_1_receive_irq,
	input  wire logic        uart_1_transmit_irq,
	input  wire logic        uart_2_receive_irq,
	input  wire logic        uart_2_transmit_irq,
	input  wire logic        converter_1_done_irq,
	input  wire logic        converter_2_done_irq,
	input  wire logic        two_wire_1_slave_irq,
	input  wire logic        two_wire_1_master_irq,
	input  wire logic        can_1_receive_irq,
	input  wire logic        can_1_event_irq,
	input  wire logic        pin_change_irq,
	// lookup request and outputs
	input  wire logic [5:0]  lookup_irq,
	input  wire logic [5:0]  lookup_vec_r,
	input  wire logic [23:0] lookup_pri_r,
	input  wire logic [23:0] lookup_alt_r,
	input  wire logic        lookup_valid_r,
	// request and pending outputs
	input  wire logic [45:0] irq_req_r,
	input  wire logic        pend_any_r,
	input  wire logic [5:0]  pend_irq_r,
	input  wire logic [5:0]  pend_vec_r,
	input  wire logic [23:0] pend_pri_r,
	input  wire logic [23:0] pend_alt_r
);
	default clocking cb @(posedge clk); endclocking
	default disable iff (!rst_n);
	a_vec_plus_eight: assert property (lookup_valid_r |->
		lookup_vec_r == $past(lookup_irq) + 6'h08) else $error("bad vector");
	a_pri_addr: assert property (lookup_valid_r |->
		lookup_pri_r == 24'h000014 + {$past(lookup_irq), 1'b0})
		else $error("bad primary address");
	a_alt_offset: assert property (lookup_valid_r |->
		lookup_alt_r == lookup_pri_r + 24'h000100) else $error("bad alternate");
	a_pend_map: assert property (pend_any_r |->
		pend_vec_r == pend_irq_r + 6'h08
		&& pend_pri_r == 24'h000014 + {pend_irq_r, 1'b0}
		&& pend_alt_r == pend_pri_r + 24'h000100) else $error("bad pend map");
	// pins pass two sync flops, so reset must be clear for all three edges
	a_ext_pins: assert property ($past(rst_n) && $past(rst_n, 2)
		&& $past(rst_n, 3) |-> irq_req_r[0] == $past(ext_pin_irq_0, 3)
		&& irq_req_r[20] == $past(ext_pin_irq_1, 3)
		&& irq_req_r[29] == $past(ext_pin_irq_2, 3)) else $error("bad pin route");
	a_capture_map: assert property ($past(rst_n) |->
		{irq_req_r[23:22], irq_req_r[40:37], irq_req_r[5], irq_req_r[1]}
		== $past(capture_irq)) else $error("bad capture route");
	a_compare_map: assert property ($past(rst_n) |->
		{irq_req_r[44:41], irq_req_r[26:25], irq_req_r[6], irq_req_r[2]}
		== $past(compare_irq)) else $error("bad compare route");
	a_xfer_map: assert property ($past(rst_n) |->
		{irq_req_r[36], irq_req_r[24], irq_req_r[14], irq_req_r[4]}
		== $past(transfer_irq)) else $error("bad transfer route");
	a_timer_map: assert property ($past(rst_n) |->
		{irq_req_r[28:27], irq_req_r[8:7], irq_req_r[3]} == $past(timer_irq))
		else $error("bad timer route");
	a_reserved_idle: assert property (irq_req_r[15] == 1'b0
		&& irq_req_r[18] == 1'b0 && irq_req_r[45] == 1'b0)
		else $error("reserved request set");
	a_serial_map: assert property ($past(rst_n) |->
		{irq_req_r[33:32], irq_req_r[10:9],
		irq_req_r[31:30], irq_req_r[12:11]}
		== $past({serial_port_2_done_irq, serial_port_2_error_irq,
		serial_port_1_done_irq, serial_port_1_error_irq,
		uart_2_transmit_irq, uart_2_receive_irq,
		uart_1_transmit_irq, uart_1_receive_irq}))
		else $error("bad serial route");
	a_misc_map: assert property (
		$past(rst_n) |-> {irq_req_r[13], irq_req_r[21],
		irq_req_r[17:16], irq_req_r[35:34], irq_req_r[19]}
		== $past({converter_1_done_irq, converter_2_done_irq,
		two_wire_1_master_irq, two_wire_1_slave_irq,
		can_1_event_irq, can_1_receive_irq, pin_change_irq}))
		else $error("bad source route");
endmodule // ivm_vector_map_chk
`default_nettype wire
